// file: common/watchdog_pkg.sv
package watchdog_pkg;

  // register indices; byte address is four times the index
  localparam logic [5:0] CTRL_IDX = 6'h2a;
  localparam logic [5:0] STAT_IDX = 6'h2b;
  localparam logic [5:0] IRQ_STAT_IDX = 6'h2c;
  localparam logic [5:0] IRQ_MASK_IDX = 6'h2d;

  // control fields and reset values
  localparam int ACT_BIT = 7;
  localparam int TOP_BIT = 6;
  localparam logic [7:0] CTRL_RESET = 8'h7f;
  localparam logic [6:0] CNT_EXPIRE = 7'h40;
  localparam int FLAG_BIT = 0;
  localparam logic [2:0] IRQ_RESET = 3'h0;

  // interrupt status bits
  localparam int EV_TIMEOUT = 0;
  localparam int EV_SOFT = 1;
  localparam int EV_HALT = 2;

  // timing
  localparam int CLK_HZ = 40_000_000;
  localparam int STEP_CYCLES = 12288;
  localparam int PULSE_NS = 500;
  localparam int PULSE_CYCLES = (PULSE_NS * (CLK_HZ / 1_000_000)) / 1000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [0:0] {
    ST_RUN = 1'b0,
    ST_PULSE = 1'b1
  } dog_state_t;

endpackage

// file: hdl/windowed_countdown_watchdog.sv
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
// What this block does
// - FFh gives 64 steps, C0h one step
// - starts disabled; only reset disables it
// - activate with top bit clear resets at once
// - deep sleep while active resets the chip
// - light sleep leaves counting unchanged
// - hardware option forces watchdog permanently active
// - activation bit set by software, reset-cleared
// - reset when count steps 40h to 3Fh
// - control resets to 7Fh
// - flag set on dog reset, cleared only by a status write of 0 or by power-on reset
// - status register always mapped; its flag reads 0 without undervoltage detector
// - decrement every 12,288 cycles
// - reset pin low for 500ns pulse
module windowed_countdown_watchdog
  import watchdog_pkg::*;
#(
  parameter int STEP_LEN = STEP_CYCLES,
  parameter bit HAS_UNDERVOLTAGE_DETECTOR = 1'b1
) (
  // clock and power-on reset
  input wire logic sys_clk_in,
  input wire logic reset_in,
  // chip side
  input wire logic ext_reset_n_in,
  input wire logic hw_option_in,
  input wire logic halt_exec_in,
  output logic dog_reset_n_out,
  output logic irq_out,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in
);

  localparam int PW = $clog2(STEP_LEN);
  localparam logic [PW-1:0] PRESC_LAST = PW'(STEP_LEN - 1);
  localparam logic [4:0] PULSE_LAST = 5'(PULSE_CYCLES - 1);

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);

  typedef struct packed {
    logic [7:0] ctrl;
    logic flag;
    logic [PW-1:0] presc;
    logic [4:0] pcnt;
    dog_state_t st;
    logic [1:0] hw_sync;
    logic [1:0] ext_sync;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic aw_got;
    logic [5:0] aw_idx;
    logic w_got;
    logic [7:0] wdat;
    logic wstb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic irq;
    logic rst_n;
  } state_t;

  localparam state_t STATE_RESET = '{
    ctrl: CTRL_RESET, flag: 1'b0, presc: '0, pcnt: 5'h00, st: ST_RUN,
    hw_sync: 2'h0, ext_sync: 2'h3, irq_stat: IRQ_RESET, irq_mask: IRQ_RESET,
    aw_got: 1'b0, aw_idx: 6'h00, w_got: 1'b0, wdat: 8'h00, wstb: 1'b0,
    awready: 1'b1, wready: 1'b1, bvalid: 1'b0, bresp: RESP_OKAY,
    arready: 1'b1, rvalid: 1'b0, rdata: 8'h00, rresp: RESP_OKAY,
    irq: 1'b0, rst_n: 1'b1
  };

  state_t s_r;
  state_t s_nxt;

  function automatic logic [5:0] reg_index(input logic [7:0] addr);
    return addr[7:2];
  endfunction

  function automatic logic mapped(input logic [5:0] idx);
    return idx == CTRL_IDX || idx == STAT_IDX || idx == IRQ_STAT_IDX || idx == IRQ_MASK_IDX;
  endfunction

  logic active;
  logic chip_rst;
  logic tick;
  logic timeout;
  logic soft_hit;
  logic halt_hit;
  logic do_write;
  logic [5:0] ridx;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.hw_sync = {s_r.hw_sync[0], hw_option_in};
    s_nxt.ext_sync = {s_r.ext_sync[0], ext_reset_n_in};
    active = s_r.ctrl[ACT_BIT] | s_r.hw_sync[1];
    chip_rst = (s_r.st == ST_PULSE) | ~s_r.ext_sync[1];
    tick = 1'b0;
    timeout = 1'b0;
    soft_hit = 1'b0;
    halt_hit = 1'b0;
    do_write = s_r.aw_got & s_r.w_got & ~s_r.bvalid;
    ridx = reg_index(s_axi_araddr_in);

    // prescaler and count; light sleep has no input here, counting pauses only during chip reset
    if (!chip_rst) begin
      if (s_r.presc == PRESC_LAST) begin
        tick = 1'b1;
        s_nxt.presc = '0;
        s_nxt.ctrl[6:0] = s_r.ctrl[6:0] - 7'h01;
        timeout = active & (s_r.ctrl[6:0] == CNT_EXPIRE);
      end else begin
        s_nxt.presc = s_r.presc + PW'(1);
      end
      halt_hit = halt_exec_in & active;
    end

    // write channels
    if (s_axi_awvalid_in && s_r.awready) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.aw_idx = reg_index(s_axi_awaddr_in);
      s_nxt.awready = 1'b0;
    end
    if (s_axi_wvalid_in && s_r.wready) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdat = s_axi_wdata_in[7:0];
      s_nxt.wstb = s_axi_wstrb_in[0];
      s_nxt.wready = 1'b0;
    end
    if (do_write) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = mapped(s_r.aw_idx) ? RESP_OKAY : RESP_DECERR;
      if (s_r.wstb) begin
        unique case (s_r.aw_idx)
          CTRL_IDX: begin
            if (!chip_rst) begin
              s_nxt.ctrl = {s_r.ctrl[ACT_BIT] | s_r.wdat[ACT_BIT], s_r.wdat[6:0]};
              s_nxt.presc = '0;
              soft_hit = (active | s_r.wdat[ACT_BIT]) & ~s_r.wdat[TOP_BIT];
              timeout = 1'b0;
            end
          end
          STAT_IDX: s_nxt.flag = s_r.flag & s_r.wdat[FLAG_BIT];
          IRQ_STAT_IDX: s_nxt.irq_stat = s_r.irq_stat & ~s_r.wdat[2:0];
          IRQ_MASK_IDX: s_nxt.irq_mask = s_r.wdat[2:0];
          default: ;
        endcase
      end
    end
    if (s_r.bvalid && s_axi_bready_in) begin
      s_nxt.bvalid = 1'b0;
      s_nxt.awready = 1'b1;
      s_nxt.wready = 1'b1;
    end

    // read channel
    if (s_axi_arvalid_in && s_r.arready) begin
      s_nxt.arready = 1'b0;
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = mapped(ridx) ? RESP_OKAY : RESP_DECERR;
      unique case (ridx)
        CTRL_IDX: s_nxt.rdata = s_r.ctrl;
        STAT_IDX: s_nxt.rdata = {7'h00, s_r.flag & HAS_UNDERVOLTAGE_DETECTOR};
        IRQ_STAT_IDX: s_nxt.rdata = {5'h00, s_r.irq_stat};
        IRQ_MASK_IDX: s_nxt.rdata = {5'h00, s_r.irq_mask};
        default: s_nxt.rdata = 8'h00;
      endcase
    end else if (s_r.rvalid && s_axi_rready_in) begin
      s_nxt.rvalid = 1'b0;
      s_nxt.arready = 1'b1;
    end

    // reset sequencer; hardware events win over software clears
    unique case (s_r.st)
      ST_RUN: begin
        if (timeout | soft_hit | halt_hit) begin
          s_nxt.st = ST_PULSE;
          s_nxt.pcnt = 5'h00;
          s_nxt.rst_n = 1'b0;
          s_nxt.flag = HAS_UNDERVOLTAGE_DETECTOR;
          s_nxt.irq_stat = s_nxt.irq_stat | {halt_hit, soft_hit, timeout};
        end
      end
      ST_PULSE: begin
        s_nxt.pcnt = s_r.pcnt + 5'h01;
        if (s_r.pcnt == PULSE_LAST) begin
          s_nxt.st = ST_RUN;
          s_nxt.rst_n = 1'b1;
        end
      end
    endcase

    // chip reset clears control but not the dog flag
    if (chip_rst || s_nxt.st == ST_PULSE) begin
      s_nxt.ctrl = CTRL_RESET;
      s_nxt.presc = '0;
    end
    s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_mask);
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      s_r <= STATE_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign dog_reset_n_out = s_r.rst_n;
  assign irq_out = s_r.irq;
  assign s_axi_awready_out = s_r.awready;
  assign s_axi_wready_out = s_r.wready;
  assign s_axi_bvalid_out = s_r.bvalid;
  assign s_axi_bresp_out = s_r.bresp;
  assign s_axi_arready_out = s_r.arready;
  assign s_axi_rvalid_out = s_r.rvalid;
  assign s_axi_rdata_out = {24'h000000, s_r.rdata};
  assign s_axi_rresp_out = s_r.rresp;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  logic wr_ctrl;
  assign wr_ctrl = do_write & s_r.wstb & (s_r.aw_idx == CTRL_IDX) & ~chip_rst;

  property p_soft_reset;
    wr_ctrl && s_r.st == ST_RUN && s_r.wdat[ACT_BIT] && !s_r.wdat[TOP_BIT]
      |=> !dog_reset_n_out && s_r.ctrl == CTRL_RESET;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset missed");

  property p_halt;
    halt_exec_in && active && !chip_rst |=> !dog_reset_n_out;
  endproperty
  a_halt: assert property (p_halt) else $error("halt while active did not reset");

  property p_expire;
    tick && active && !wr_ctrl && s_r.st == ST_RUN && s_r.ctrl[6:0] == CNT_EXPIRE
      |=> !dog_reset_n_out;
  endproperty
  a_expire: assert property (p_expire) else $error("expiry did not reset");

  property p_pulse_len;
    $fell(dog_reset_n_out) |-> ##19 !dog_reset_n_out ##1 dog_reset_n_out;
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("reset pulse not 20 cycles");

  property p_act_sticky;
    s_r.ctrl[ACT_BIT] && !chip_rst && !(s_nxt.st == ST_PULSE) |=> s_r.ctrl[ACT_BIT];
  endproperty
  a_act_sticky: assert property (p_act_sticky) else $error("activation cleared");

  property p_ctrl_in_pulse;
    !dog_reset_n_out |-> s_r.ctrl == CTRL_RESET && s_r.presc == '0;
  endproperty
  a_ctrl_in_pulse: assert property (p_ctrl_in_pulse) else $error("control not 7fh");

  property p_flag;
    $fell(dog_reset_n_out) |-> s_r.flag == HAS_UNDERVOLTAGE_DETECTOR;
  endproperty
  a_flag: assert property (p_flag) else $error("dog flag not set");

  property p_step;
    !chip_rst && !wr_ctrl && !halt_hit && s_r.presc != PRESC_LAST |=> $stable(s_r.ctrl[6:0]);
  endproperty
  a_step: assert property (p_step) else $error("count moved off step");

  property p_load;
    wr_ctrl && !halt_hit && !s_r.wdat[ACT_BIT] && s_r.wdat[TOP_BIT] && s_r.st == ST_RUN
      |=> s_r.presc == '0 && s_r.ctrl[6:0] == $past(s_r.wdat[6:0]);
  endproperty
  a_load: assert property (p_load) else $error("control write not loaded");

  property p_hw;
    wr_ctrl && s_r.hw_sync[1] && !s_r.wdat[TOP_BIT] |=> !dog_reset_n_out;
  endproperty
  a_hw: assert property (p_hw) else $error("hardware option not active");

  property p_flag_keep;
    s_r.flag && !(do_write && s_r.wstb && s_r.aw_idx == STAT_IDX) |=> s_r.flag;
  endproperty
  a_flag_keep: assert property (p_flag_keep) else $error("dog flag lost");

  property p_ext_ctrl;
    !s_r.ext_sync[1] |=> s_r.ctrl == CTRL_RESET && s_r.presc == '0;
  endproperty
  a_ext_ctrl: assert property (p_ext_ctrl) else $error("chip reset left control");

  property p_halt_idle;
    halt_exec_in && !active && !chip_rst && !wr_ctrl |=> dog_reset_n_out;
  endproperty
  a_halt_idle: assert property (p_halt_idle) else $error("halt reset while idle");

  property p_act_set;
    !s_r.ctrl[ACT_BIT] && !wr_ctrl |=> !s_r.ctrl[ACT_BIT];
  endproperty
  a_act_set: assert property (p_act_set) else $error("activation set by hardware");

  property p_tick_dec;
    tick && !wr_ctrl && !halt_hit && !timeout
      |=> s_r.ctrl[6:0] == $past(s_r.ctrl[6:0]) - 7'h01;
  endproperty
  a_tick_dec: assert property (p_tick_dec) else $error("count did not step down");

  c_expire: cover property (timeout);
  c_soft: cover property (soft_hit);
  c_halt: cover property (halt_hit);
  c_irq: cover property ($rose(irq_out));
  c_ext: cover property (!s_r.ext_sync[1]);

endmodule

// file: verif/windowed_countdown_watchdog_tb_top.sv
`timescale 1ns/1ps
module windowed_countdown_watchdog_tb_top;
  import watchdog_pkg::*;
  localparam int S = 8;
  logic sys_clk_in = 0, reset_in = 1, ext_n = 1, hw_opt = 0, halt = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0;
  logic awvalid = 0, wvalid = 0, arvalid = 0, bready = 1, rready = 1;
  logic awready, wready, bvalid, arready, rvalid, dog_n, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [33:0] exp_q[$];
  logic [1:0] bq[$];
  logic [1:0] wexp = RESP_OKAY;
  logic dog_q = 1;
  logic [31:0] seed = 32'd88080;
  int fail_count = 0, n_compared = 0, pulses = 0;

  windowed_countdown_watchdog #(.STEP_LEN(S), .HAS_UNDERVOLTAGE_DETECTOR(1'b1)) DUT (
    .sys_clk_in(sys_clk_in), .reset_in(reset_in), .ext_reset_n_in(ext_n),
    .hw_option_in(hw_opt), .halt_exec_in(halt), .dog_reset_n_out(dog_n), .irq_out(irq),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready));

  initial begin
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end

  // --------------------------------------------------------------
  // bus tasks and checks
  // --------------------------------------------------------------
  function automatic logic [31:0] nxt(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    if (exp_q.size() != 0 || bq.size() != 0) fail_count++;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    bit a;
    bit w;
    bq.push_back(wexp);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1;
    wvalid <= 1;
    a = 0;
    w = 0;
    while (!(a && w)) begin
      @(posedge sys_clk_in);
      if (!a && awready === 1'b1) begin
        a = 1;
        awvalid <= 0;
      end
      if (!w && wready === 1'b1) begin
        w = 1;
        wvalid <= 0;
      end
    end
    while (bvalid !== 1'b1) begin
      @(posedge sys_clk_in);
    end
  endtask

  task automatic rd(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] r);
    bit t;
    exp_q.push_back({r, 24'h0, d});
    araddr <= {idx, 2'b00};
    arvalid <= 1;
    t = 0;
    while (!t) begin
      @(posedge sys_clk_in);
      if (arready === 1'b1) begin
        t = 1;
        arvalid <= 0;
      end
    end
    while (rvalid !== 1'b1) begin
      @(posedge sys_clk_in);
    end
  endtask

  task automatic wait_pulse(input int lo, input int hi);
    int c;
    int w;
    c = 0;
    w = 0;
    while (dog_n !== 1'b0 && c < 2000) begin
      @(posedge sys_clk_in);
      c++;
    end
    check(c >= lo && c <= hi, 1);
    while (dog_n === 1'b0 && w < 100) begin
      @(posedge sys_clk_in);
      w++;
    end
    check(w, PULSE_CYCLES);
  endtask

  task automatic pulse_halt();
    halt <= 1;
    @(posedge sys_clk_in);
    halt <= 0;
  endtask

  always @(posedge sys_clk_in) begin
    dog_q <= dog_n;
    if (dog_q === 1'b1 && dog_n === 1'b0) pulses <= pulses + 1;
    if (rvalid === 1'b1 && rready) check({rresp, rdata}, exp_q.pop_front());
    if (bvalid === 1'b1 && bready) check(bresp, bq.pop_front());
  end

  initial begin
    repeat (20000) @(posedge sys_clk_in);
    fail_count++;
    final_report();
  end

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    int p0;
    repeat (5) @(posedge sys_clk_in);
    reset_in <= 0;
    @(posedge sys_clk_in);
    rd(CTRL_IDX, CTRL_RESET, RESP_OKAY);
    rd(STAT_IDX, 8'h00, RESP_OKAY);
    rd(IRQ_STAT_IDX, 8'h00, RESP_OKAY);
    rd(6'h3f, 8'h00, RESP_DECERR);
    wexp = RESP_DECERR;
    wr(6'h3f, 8'h55);
    wexp = RESP_OKAY;
    p0 = pulses;
    wr(CTRL_IDX, 8'h3f);
    wr(CTRL_IDX, 8'h40);
    pulse_halt();
    repeat (5 * S) @(posedge sys_clk_in);
    check(pulses - p0, 0);
    wr(CTRL_IDX, 8'hc0);
    wait_pulse(S - 3, S + 3);
    rd(CTRL_IDX, CTRL_RESET, RESP_OKAY);
    rd(STAT_IDX, 8'h01, RESP_OKAY);
    rd(IRQ_STAT_IDX, 8'h01, RESP_OKAY);
    check(irq, 0);
    wr(IRQ_MASK_IDX, 8'h01);
    repeat (2) @(posedge sys_clk_in);
    check(irq, 1);
    wr(IRQ_STAT_IDX, 8'h01);
    repeat (2) @(posedge sys_clk_in);
    check(irq, 0);
    wr(CTRL_IDX, 8'hff);
    wait_pulse(64 * S - 3, 64 * S + 3);
    wr(CTRL_IDX, 8'hff);
    wr(CTRL_IDX, 8'h7f);
    rd(CTRL_IDX, 8'hff, RESP_OKAY);
    pulse_halt();
    wait_pulse(0, 3);
    wr(CTRL_IDX, 8'hbf);
    wait_pulse(0, 3);
    rd(IRQ_STAT_IDX, 8'h07, RESP_OKAY);
    p0 = pulses;
    for (int i = 0; i < 20; i++) begin
      seed = nxt(seed);
      wr(CTRL_IDX, {3'b111, seed[4:0]});
      repeat (seed[10:8]) @(posedge sys_clk_in);
    end
    ext_n <= 0;
    repeat (4) @(posedge sys_clk_in);
    ext_n <= 1;
    repeat (4) @(posedge sys_clk_in);
    check(pulses - p0, 0);
    rd(CTRL_IDX, CTRL_RESET, RESP_OKAY);
    rd(STAT_IDX, 8'h01, RESP_OKAY);
    wr(STAT_IDX, 8'h00);
    rd(STAT_IDX, 8'h00, RESP_OKAY);
    hw_opt <= 1;
    repeat (4) @(posedge sys_clk_in);
    wr(CTRL_IDX, 8'h3f);
    wait_pulse(0, 3);
    hw_opt <= 0;
    repeat (4) @(posedge sys_clk_in);
    reset_in <= 1;
    repeat (3) @(posedge sys_clk_in);
    reset_in <= 0;
    @(posedge sys_clk_in);
    rd(STAT_IDX, 8'h00, RESP_OKAY);
    rd(CTRL_IDX, CTRL_RESET, RESP_OKAY);
    check(irq, 0);
    repeat (2) @(posedge sys_clk_in);
    final_report();
  end
endmodule
